// file: hdl/ddrsr_core.sv
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
// Behaviour
// [RULE1] Rate change applies new timings at once
// [RULE2] Even double-rate count before rate change
// [RULE3] Even double-rate count between single refreshes
// [RULE4] Quad-rate count multiple of four before change
// [RULE5] Quad count multiple of four between singles
// [RULE6] Temperature refresh needs fixed 1x mode
// [RULE7] Odd double count needs extra refresh after exit
// [RULE8] Partial quad group needs extra refresh after exit
// [RULE9] Entry decode: CS RAS CAS CKE low
// [RULE10] Controller idles device before entry
// [RULE11] CKE low holds self refresh; inputs ignored
// [RULE12] ODT and DLL off in, on with reset out
// [RULE13] Vref bit picks tXS or tXSDLL for writes
// [RULE14] Internal refresh within tCKE, timer keeps refreshing
// [RULE15] Controller respects tCKESR, tCKSRE, tCKSRX
// [RULE16] Exit: CKE high with deselect; tXS classes
// [RULE17] Only listed mode writes under tXS_FAST
// [RULE18] Reads and writes wait tXSDLL
// [RULE19] Deselect during tXS; ODT off, CKE high
// [RULE20] Extra refresh needed before re-entry
// [RULE21] tXS equals tRFC1 plus 10ns
// [RULE22] Abort bit: cut refresh, tXS_ABORT applies
// [RULE23] On-the-fly: BG0 picks refresh rate
// [RULE24] Mode field encodings, others reserved
// [RULE25] Controller tracks sub-rate count modulo four
module ddrsr_core (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic cke_pin_i,
  input wire logic cs_n_pin_i,
  input wire logic act_n_pin_i,
  input wire logic ras_n_pin_i,
  input wire logic cas_n_pin_i,
  input wire logic we_n_pin_i,
  input wire logic bg0_pin_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic self_refresh_o,
  output logic odt_enable_o,
  output logic dll_enable_o,
  output logic dll_reset_o,
  output logic vref_on_o,
  output logic int_refresh_o,
  output logic [1:0] ref_kind_o,
  output logic nodll_ok_o,
  output logic fast_ok_o,
  output logic dll_ok_o,
  output logic write_ok_o,
  output logic extra_ref_o
);
  import ddrsr_pkg::*;
  localparam logic [CNT_W-1:0] L_TXS = CNT_W'(TXS_CYC);
  localparam logic [CNT_W-1:0] L_ABORT = CNT_W'(TXS_ABORT_CYC);
  localparam logic [CNT_W-1:0] L_FAST = CNT_W'(TXS_FAST_CYC);
  localparam logic [CNT_W-1:0] L_DLL = CNT_W'(TXSDLL_NCK);
  localparam logic [CNT_W-1:0] L_RFC1 = CNT_W'(TRFC1_CYC);
  localparam logic [CNT_W-1:0] L_RFC2 = CNT_W'(TRFC2_CYC);
  localparam logic [CNT_W-1:0] L_RFC4 = CNT_W'(TRFC4_CYC);
  localparam logic [CNT_W-1:0] L_TCKE = CNT_W'(TCKE_CYC);
  localparam logic [CNT_W-1:0] L_REFI = CNT_W'(TREFI_CYC);

  // Pin synchronisers, two stages each
  logic [6:0] pin_raw;
  logic [6:0] sy1_r;
  logic [6:0] sy2_r;
  assign pin_raw = {bg0_pin_i, we_n_pin_i, cas_n_pin_i, ras_n_pin_i, act_n_pin_i, cs_n_pin_i, cke_pin_i};
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sy1_r <= 7'h3F;
      sy2_r <= 7'h3F;
    end else if (ce_i) begin
      sy1_r <= pin_raw;
      sy2_r <= sy1_r;
    end
  end
  logic cke_s, cs_s, act_s, ras_s, cas_s, we_s, bg0_s;
  assign {bg0_s, we_s, cas_s, ras_s, act_s, cs_s, cke_s} = sy2_r;
  logic cke_d_r;
  logic cmd_ref, cmd_sre, cmd_srx;
  assign cmd_ref = ~cs_s & act_s & ~ras_s & ~cas_s & we_s & cke_s;
  assign cmd_sre = ~cs_s & act_s & ~ras_s & ~cas_s & we_s & ~cke_s & cke_d_r; // RULE9
  assign cmd_srx = cke_s & ~cke_d_r & cs_s; // RULE16

  // Exit and internal refresh timers share one module, one instance per class
  ddrsr_tmr_if t_nodll();
  ddrsr_tmr_if t_fast();
  ddrsr_tmr_if t_dll();
  ddrsr_tmr_if t_int();
  ddrsr_timer u_nodll (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .t(t_nodll));
  ddrsr_timer u_fast (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .t(t_fast));
  ddrsr_timer u_dll (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .t(t_dll));
  ddrsr_timer u_int (.mclk_i(mclk_i), .srst_i(srst_i), .ce_i(ce_i), .t(t_int));

  ddrsr_state_t st_r, st_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [1:0] sub_cnt_r, sub_cnt_nxt;
  logic extra_r, extra_nxt;
  logic [CNT_W-1:0] refi_r, refi_nxt;
  logic refbusy_r, refbusy_nxt;
  logic [1:0] kind_r, kind_nxt;
  logic dllrst_r, dllrst_nxt;
  logic [31:0] rdata_nxt;
  logic mode_bad_r, mode_bad_nxt;
  logic [2:0] rmode;
  assign rmode = mode_r[MODE_RM_LSB +: 3];

  always_comb begin
    st_nxt = st_r;
    mode_nxt = mode_r;
    sub_cnt_nxt = sub_cnt_r;
    extra_nxt = extra_r;
    refi_nxt = refi_r;
    refbusy_nxt = refbusy_r & t_int.busy;
    kind_nxt = kind_r;
    dllrst_nxt = 1'b0;
    mode_bad_nxt = mode_bad_r;
    t_nodll.start = 1'b0;
    t_nodll.load = L_TXS;
    t_fast.start = 1'b0;
    t_fast.load = L_FAST;
    t_dll.start = 1'b0;
    t_dll.load = L_DLL;
    t_int.start = 1'b0;
    t_int.load = L_RFC1;
    rdata_nxt = 32'h0;
    // Register port; writes to mode regroup the sub-rate count
    if (wr_i && addr_i == REG_MODE) begin
      mode_nxt = wdata_i[7:0]; // RULE1
      sub_cnt_nxt = 2'h0;
      // Flag illegal mode: reserved code or temperature refresh with non-normal rate
      mode_bad_nxt = (wdata_i[2:0] == 3'h3) || (wdata_i[2:0] == 3'h4) || (wdata_i[2:0] == 3'h7)
        || (wdata_i[MODE_TEMP_BIT] && wdata_i[2:0] != RM_FIX1); // RULE6 RULE24
    end
    if (rd_i) begin
      if (addr_i == REG_MODE) begin
        rdata_nxt = {24'h0, mode_r};
      end else if (addr_i == REG_STATUS) begin
        rdata_nxt = {26'h0, mode_bad_r, extra_r, refbusy_r, dll_enable_o, st_r};
      end else if (addr_i == REG_REFCNT) begin
        rdata_nxt = {30'h0, sub_cnt_r};
      end else if (addr_i == REG_TIMING) begin
        rdata_nxt = {20'h0, L_TXS};
      end else begin
        rdata_nxt = 32'h0;
      end
    end
    case (st_r)
      SR_IDLE: begin
        if (cmd_ref) begin
          // Kind per mode and BG0
          if (rmode == RM_FIX2 || (rmode == RM_FLY12 && bg0_s)) begin // RULE23
            kind_nxt = RK_2X;
            t_int.load = L_RFC2;
          end else if (rmode == RM_FIX4 || (rmode == RM_FLY14 && bg0_s)) begin // RULE23
            kind_nxt = RK_4X;
            t_int.load = L_RFC4;
          end else begin
            kind_nxt = RK_1X;
            t_int.load = L_RFC1;
          end
          t_int.start = 1'b1; // RULE1
          refbusy_nxt = 1'b1;
          extra_nxt = 1'b0;
          if (kind_nxt == RK_1X) begin
            sub_cnt_nxt = 2'h0;
          end else begin
            sub_cnt_nxt = sub_cnt_r + 2'h1;
          end
        end else if (cmd_sre) begin
          st_nxt = SR_SELF; // RULE11
          refi_nxt = L_TCKE; // RULE14
          // Owed extra refresh: incomplete group or device rule
          extra_nxt = 1'b1; // RULE7 RULE8 RULE20
        end
      end
      SR_SELF: begin
        // Internal timer refresh, first within tCKE
        if (refi_r == '0) begin
          refi_nxt = L_REFI; // RULE14
          t_int.start = 1'b1;
          t_int.load = L_RFC1;
          refbusy_nxt = 1'b1;
        end else begin
          refi_nxt = refi_r - 1'b1;
        end
        if (cmd_srx) begin
          st_nxt = SR_EXIT;
          dllrst_nxt = 1'b1; // RULE12
          sub_cnt_nxt = 2'h0;
          if (mode_r[MODE_ABORT_BIT]) begin
            t_nodll.load = L_ABORT; // RULE22
            refbusy_nxt = 1'b0;
            t_int.start = 1'b1;
            t_int.load = '0;
          end else begin
            t_nodll.load = L_TXS; // RULE21
          end
          t_nodll.start = 1'b1;
          t_fast.start = 1'b1; // RULE17
          t_dll.start = 1'b1; // RULE18
        end
      end
      SR_EXIT: begin
        // Deselect window closes when tXSDLL ends
        if (!t_dll.busy) begin
          st_nxt = SR_IDLE; // RULE19
        end
      end
      default: st_nxt = SR_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st_r <= SR_IDLE;
      mode_r <= MODE_RESET;
      sub_cnt_r <= 2'h0;
      extra_r <= 1'b0;
      refi_r <= '0;
      refbusy_r <= 1'b0;
      kind_r <= RK_1X;
      dllrst_r <= 1'b0;
      mode_bad_r <= 1'b0;
      cke_d_r <= 1'b1;
      rdata_o <= 32'h0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      mode_r <= mode_nxt;
      sub_cnt_r <= sub_cnt_nxt;
      extra_r <= extra_nxt;
      refi_r <= refi_nxt;
      refbusy_r <= refbusy_nxt;
      kind_r <= kind_nxt;
      dllrst_r <= dllrst_nxt;
      mode_bad_r <= mode_bad_nxt;
      cke_d_r <= cke_s;
      rdata_o <= rdata_nxt;
    end
  end

  // Output flops
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      self_refresh_o <= 1'b0;
      odt_enable_o <= 1'b1;
      dll_enable_o <= 1'b1;
      dll_reset_o <= 1'b0;
      vref_on_o <= 1'b1;
      int_refresh_o <= 1'b0;
      ref_kind_o <= 2'h0;
      nodll_ok_o <= 1'b1;
      fast_ok_o <= 1'b1;
      dll_ok_o <= 1'b1;
      write_ok_o <= 1'b1;
      extra_ref_o <= 1'b0;
    end else if (ce_i) begin
      self_refresh_o <= (st_nxt == SR_SELF);
      odt_enable_o <= (st_nxt != SR_SELF); // RULE12
      dll_enable_o <= (st_nxt != SR_SELF); // RULE12
      dll_reset_o <= dllrst_nxt;
      vref_on_o <= (st_nxt != SR_SELF) | mode_r[MODE_VREF_BIT]; // RULE13
      int_refresh_o <= refbusy_nxt;
      ref_kind_o <= kind_nxt;
      nodll_ok_o <= (st_r != SR_SELF) & ~t_nodll.busy & ~t_nodll.start; // RULE16
      fast_ok_o <= (st_r != SR_SELF) & ~t_fast.busy & ~t_fast.start;
      dll_ok_o <= (st_r != SR_SELF) & ~t_dll.busy & ~t_dll.start;
      // Writes need vref: tXS if kept on, else tXSDLL
      write_ok_o <= mode_r[MODE_VREF_BIT] ? ((st_r != SR_SELF) & ~t_nodll.busy & ~t_nodll.start)
        : ((st_r != SR_SELF) & ~t_dll.busy & ~t_dll.start); // RULE13
      extra_ref_o <= extra_nxt;
    end
  end
endmodule

// file: hdl/ddrsr_pkg.sv
package ddrsr_pkg;
  // Refresh mode field codes
  localparam logic [2:0] RM_FIX1 = 3'h0;
  localparam logic [2:0] RM_FIX2 = 3'h1;
  localparam logic [2:0] RM_FIX4 = 3'h2;
  localparam logic [2:0] RM_FLY12 = 3'h5;
  localparam logic [2:0] RM_FLY14 = 3'h6;
  localparam logic [2:0] RM_RESET = 3'h0;
  // Unused bit constants; the mode register uses MODE_VREF_BIT and MODE_ABORT_BIT
  localparam int VREF_KEEP_BIT = 7;
  localparam int ABORT_EN_BIT = 9;
  // Register offsets
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_REFCNT = 4'h2;
  localparam logic [3:0] REG_TIMING = 4'h3;
  // Mode register field positions
  localparam int MODE_RM_LSB = 0;
  localparam int MODE_TEMP_BIT = 3;
  localparam int MODE_VREF_BIT = 4;
  localparam int MODE_ABORT_BIT = 5;
  localparam logic [7:0] MODE_RESET = 8'h00;
  // Timing (clock 200 MHz)
  localparam int CLK_PS = 5000;
  localparam int TRFC1_PS = 350000;
  localparam int TRFC2_PS = 260000;
  localparam int TRFC4_PS = 160000;
  localparam int TXS_EXTRA_PS = 10000;
  localparam int TXS_CYC = (TRFC1_PS + TXS_EXTRA_PS + CLK_PS - 1) / CLK_PS;
  localparam int TXS_FAST_CYC = (TRFC4_PS + TXS_EXTRA_PS + CLK_PS - 1) / CLK_PS;
  localparam int TXS_ABORT_CYC = TXS_FAST_CYC;
  localparam int TXSDLL_NCK = 768;
  localparam int TCKE_PS = 5000;
  localparam int TCKE_CYC = (TCKE_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRFC1_CYC = (TRFC1_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRFC2_CYC = (TRFC2_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRFC4_CYC = (TRFC4_PS + CLK_PS - 1) / CLK_PS;
  localparam int TREFI_BASE_NS = 7800;
  localparam int TREFI_CYC = (TREFI_BASE_NS * 1000) / CLK_PS;
  localparam int CNT_W = 12;
  typedef enum logic [1:0] {SR_IDLE, SR_SELF, SR_EXIT} ddrsr_state_t;
  typedef enum logic [1:0] {RK_1X, RK_2X, RK_4X} ddrsr_rate_t;
endpackage

// file: hdl/ddrsr_timer.sv
`timescale 1ns/100ps
module ddrsr_timer (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  ddrsr_tmr_if.tmr t
);
  import ddrsr_pkg::*;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (t.start) begin
      cnt_nxt = t.load;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      cnt_r <= cnt_nxt;
    end
  end
  assign t.busy = (cnt_r != '0);
endmodule

// file: hdl/ddrsr_tmr_if.sv
`timescale 1ns/100ps
interface ddrsr_tmr_if;
  import ddrsr_pkg::*;
  logic start;
  logic [CNT_W-1:0] load;
  logic busy;
  modport ctl(output start, output load, input busy);
  modport tmr(input start, input load, output busy);
endinterface

// file: testbench/ddr4_refresh_rate_and_self_refresh_tb.sv
`timescale 1ns/100ps
module ddr4_refresh_rate_and_self_refresh_tb;
  import ddrsr_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i, ce_i, wr_i, rd_i, bg0_pin_i;
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [5:0] pins;
  logic self_refresh_o, odt_enable_o, dll_enable_o, dll_reset_o, vref_on_o, int_refresh_o;
  logic nodll_ok_o, fast_ok_o, dll_ok_o, write_ok_o, extra_ref_o;
  logic [1:0] ref_kind_o;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [2:0] codes [5] = '{RM_FIX1, RM_FIX2, RM_FIX4, RM_FLY12, RM_FLY14};
  int n_pad [5] = '{0, 0, 2, 1, 3};
  logic [1:0] n_sub [5] = '{2'h0, 2'h2, 2'h0, 2'h2, 2'h0};
  logic [31:0] bad_mode [5] = '{32'h3, 32'h4, 32'h7, 32'h8, 32'h9};
  logic bad_exp [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic [1:0] k_lo [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
  logic [1:0] k_hi [5] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
  always #2.5 mclk_i = ~mclk_i;
  ddrsr_ctl_model ctl (.mclk_i, .cmd_o(pins), .bg0_o(bg0_pin_i));
  ddrsr_core uut (.mclk_i, .srst_i, .ce_i, .cke_pin_i(pins[5]), .cs_n_pin_i(pins[4]), .act_n_pin_i(pins[3]),
    .ras_n_pin_i(pins[2]), .cas_n_pin_i(pins[1]), .we_n_pin_i(pins[0]), .bg0_pin_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .self_refresh_o, .odt_enable_o, .dll_enable_o, .dll_reset_o, .vref_on_o, .int_refresh_o,
    .ref_kind_o, .nodll_ok_o, .fast_ok_o, .dll_ok_o, .write_ok_o, .extra_ref_o);
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // Records the last cycle each flag was low, counted from the exit command
  task automatic sr_cycle(input logic [31:0] m, input int e_nd, input int e_wr);
    int l_nd = 0;
    int l_fa = 0;
    int l_dl = 0;
    int l_wr = 0;
    wr(REG_MODE, m);
    ctl.sr_enter();
    chk("in self refresh", self_refresh_o, 1);
    chk("odt in self refresh", odt_enable_o, 0);
    chk("vref in self refresh", vref_on_o, m[MODE_VREF_BIT]);
    chk("extra owed", extra_ref_o, 1);
    ctl.sr_exit();
    for (int i = 0; i < TXSDLL_NCK + 20; i++) begin
      @(posedge mclk_i);
      #1;
      if (nodll_ok_o !== 1'b1) l_nd = i;
      if (fast_ok_o !== 1'b1) l_fa = i;
      if (dll_ok_o !== 1'b1) l_dl = i;
      if (write_ok_o !== 1'b1) l_wr = i;
    end
    chk("txs", l_nd >= e_nd - 2 && l_nd <= e_nd + 6, 1);
    chk("txs fast", l_fa >= TXS_FAST_CYC - 2 && l_fa <= TXS_FAST_CYC + 6, 1);
    chk("txsdll", l_dl >= TXSDLL_NCK - 2 && l_dl <= TXSDLL_NCK + 6, 1);
    chk("first write", l_wr >= e_wr - 2 && l_wr <= e_wr + 6, 1);
    chk("odt back", odt_enable_o, 1);
    chk("dll back", dll_enable_o, 1);
    ctl.refresh(1'b0);
    chk("extra paid", extra_ref_o, 0);
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc > 8000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    srst_i = 1'b1;
    ce_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    repeat (5) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd(REG_MODE);
    chk("mode reset", d, 32'(MODE_RESET));
    rd(REG_TIMING);
    chk("txs cycles", d, 32'(TXS_CYC));
    rd(4'hF);
    chk("unmapped", d, 32'h0);
    // Write while frozen must not land
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(REG_MODE, 32'h1);
    ce_i <= 1'b1;
    rd(REG_MODE);
    chk("frozen by ce", d, 32'(MODE_RESET));
    for (int i = 0; i < 5; i++) begin
      wr(REG_MODE, 32'(codes[i]));
      rd(REG_STATUS);
      chk("mode accepted", d[5], 1'b0);
      ctl.refresh(1'b0);
      chk("kind low", ref_kind_o, k_lo[i]);
      ctl.refresh(1'b1);
      chk("kind high", ref_kind_o, k_hi[i]);
      // Complete the sub-rate group before the next rate change
      repeat (n_pad[i]) ctl.refresh(1'b1);
      rd(REG_REFCNT);
      chk("sub-rate count", d, 32'(n_sub[i]));
    end
    foreach (bad_mode[i]) begin
      wr(REG_MODE, bad_mode[i]);
      rd(REG_STATUS);
      chk("illegal mode", d[5], bad_exp[i]);
    end
    sr_cycle(32'h10, TXS_CYC, TXS_CYC);
    sr_cycle(32'h20, TXS_ABORT_CYC, TXSDLL_NCK);
    tally_and_finish();
  end
endmodule

// file: testbench/ddrsr_ctl_model.sv
`timescale 1ns/100ps
module ddrsr_ctl_model
  import ddrsr_pkg::*;
(
  input wire logic mclk_i,
  output logic [5:0] cmd_o,
  output logic bg0_o
);
  // Order: cke, cs_n, act_n, ras_n, cas_n, we_n
  localparam logic [4:0] REF_P = 5'h09;
  localparam logic [4:0] DES_P = 5'h1F;
  localparam int TCKESR_CYC = 16;
  initial begin
    cmd_o = {1'b1, DES_P};
    bg0_o = 1'b0;
  end
  task automatic cmd(input logic c, input logic [4:0] p, input logic b);
    @(posedge mclk_i);
    cmd_o <= {c, p};
    bg0_o <= b;
  endtask
  task automatic refresh(input logic b);
    cmd(1'b1, REF_P, b);
    cmd(1'b1, DES_P, ~b);
    repeat (TRFC1_CYC + 2) @(posedge mclk_i);
  endtask
  task automatic sr_enter();
    cmd(1'b0, REF_P, 1'b0);
    // Junk on the bus proves it is ignored while cke is low
    for (int i = 0; i < TCKESR_CYC; i++) begin
      cmd(1'b0, 5'(i), i[0]);
    end
  endtask
  task automatic sr_exit();
    cmd(1'b1, DES_P, 1'b0);
  endtask
endmodule

// file: testbench/ddrsr_properties.sv
`timescale 1ns/100ps
module ddrsr_properties
  import ddrsr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic cke_pin_i,
  input wire logic cs_n_pin_i,
  input wire logic act_n_pin_i,
  input wire logic ras_n_pin_i,
  input wire logic cas_n_pin_i,
  input wire logic we_n_pin_i,
  input wire logic self_refresh_o,
  input wire logic odt_enable_o,
  input wire logic dll_enable_o,
  input wire logic dll_reset_o,
  input wire logic int_refresh_o,
  input wire logic nodll_ok_o,
  input wire logic fast_ok_o,
  input wire logic dll_ok_o,
  input wire logic extra_ref_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  int unsigned cnt_r;
  int unsigned cnt_nxt;
  // Cycles since self refresh ended; saturates so it never wraps into a window
  always_comb begin
    cnt_nxt = cnt_r;
    if (srst_i || self_refresh_o) begin
      cnt_nxt = 0;
    end else if (cnt_r < 1023) begin
      cnt_nxt = cnt_r + 1;
    end
  end
  always_ff @(posedge mclk_i) begin
    cnt_r <= cnt_nxt;
  end
  a_entry_decode: assert property (
    !cs_n_pin_i && !ras_n_pin_i && !cas_n_pin_i && we_n_pin_i && act_n_pin_i && $fell(cke_pin_i)
    && !self_refresh_o |-> ##[2:5] self_refresh_o) else $error("self refresh entry not taken");
  a_sr_held: assert property (
    (!cke_pin_i) [*4] ##0 self_refresh_o |=> self_refresh_o) else $error("self refresh left with cke low");
  a_sr_quiet: assert property (
    self_refresh_o && $past(self_refresh_o) |-> !odt_enable_o && !dll_enable_o) else $error("odt or dll on");
  a_exit_dll_reset: assert property (
    $fell(self_refresh_o) |-> ##[0:2] dll_reset_o) else $error("no dll reset on exit");
  a_int_refresh: assert property (
    $rose(self_refresh_o) |-> ##[0:2] int_refresh_o) else $error("no internal refresh");
  a_extra_owed: assert property (
    $rose(self_refresh_o) |-> ##[0:2] extra_ref_o) else $error("extra refresh not owed");
  a_flags_drop: assert property (
    $fell(self_refresh_o) |-> ##[0:2] !nodll_ok_o) else $error("exit delay not started");
  a_xs_class: assert property (
    $rose(nodll_ok_o) |-> cnt_r + 3 >= TXS_ABORT_CYC && cnt_r <= TXS_CYC + 3) else $error("exit delay wrong");
  a_fast_time: assert property (
    $rose(fast_ok_o) |-> cnt_r + 3 >= TXS_FAST_CYC && cnt_r <= TXS_FAST_CYC + 3) else $error("fast delay wrong");
  a_dll_time: assert property (
    $rose(dll_ok_o) |-> cnt_r + 3 >= TXSDLL_NCK && cnt_r <= TXSDLL_NCK + 3) else $error("dll delay wrong");
  a_flags_bound: assert property (
    cnt_r == TXSDLL_NCK + 4 |-> nodll_ok_o && fast_ok_o && dll_ok_o) else $error("exit flags stuck low");
  c_exit: cover property ($fell(self_refresh_o));
  c_dll_ready: cover property ($rose(dll_ok_o));
  c_extra_paid: cover property ($fell(extra_ref_o));
endmodule
bind ddrsr_core ddrsr_properties chk (.mclk_i, .srst_i, .cke_pin_i, .cs_n_pin_i, .act_n_pin_i, .ras_n_pin_i,
  .cas_n_pin_i, .we_n_pin_i, .self_refresh_o, .odt_enable_o, .dll_enable_o, .dll_reset_o, .int_refresh_o,
  .nodll_ok_o, .fast_ok_o, .dll_ok_o, .extra_ref_o);
